// File: design/pcmt_pkg.sv
/*
 Types shared by the colour matrix block. Assumes pcmt_regs.svh for numbers.
*/
package pcmt_pkg;
	typedef logic [15:0] coef_t;
	typedef logic [11:0][15:0] coef_set_t;
	typedef enum logic [0:0] {
		MATRIX_CORRECTION  = 1'b0,
		MATRIX_LUMA_CHROMA = 1'b1
	} matrix_sel_e;
	typedef enum logic [2:0] {
		ILLUM_GENERAL  = 3'b000,
		ILLUM_TUNGSTEN = 3'b001,
		ILLUM_WARM_FL  = 3'b010,
		ILLUM_COOL_FL  = 3'b011,
		ILLUM_DAYLIGHT = 3'b100,
		ILLUM_CLOUDY   = 3'b101,
		ILLUM_SHADE    = 3'b110,
		ILLUM_CUSTOM   = 3'b111
	} illuminant_e;
endpackage

// File: design/pcmt_regs.svh
/*
 Register offsets, field positions, reset values and fixed figures of the
 colour matrix block. Assumes a byte-addressed APB with 32-bit data.
*/
`ifndef PCMT_REGS_SVH
`define PCMT_REGS_SVH

`define PCMT_REG_CTRL      8'h00
`define PCMT_REG_SELECT    8'h04
`define PCMT_REG_COEF      8'h08
`define PCMT_REG_PRESET    8'h0C
`define PCMT_REG_WB_RED    8'h10
`define PCMT_REG_WB_BLUE   8'h14
`define PCMT_REG_SAT       8'h18
`define PCMT_REG_STATUS    8'h1C

`define PCMT_CTRL_PIPE_BIT 0
`define PCMT_CTRL_CCM_BIT  1
`define PCMT_CTRL_SAT_BIT  2
`define PCMT_CTRL_YUV_BIT  3
`define PCMT_SEL_MAT_BIT   0
`define PCMT_SEL_IDX_LSB   4
`define PCMT_SEL_IDX_MSB   7
`define PCMT_STAT_LVL_LSB  16
`define PCMT_STAT_LVL_MSB  20

`define PCMT_NUM_COEFS     4'hC
`define PCMT_COEF_ONE      16'h0100
`define PCMT_SAT_RESET     16'h0100
`define PCMT_WB_RESET      16'h0100
`define PCMT_FRAC_BITS     8
`define PCMT_FIFO_DEPTH    16
`define PCMT_PIX_WIDTH     24

`endif

// File: design/pixel_color_matrix_transform.sv
/*
 Pixel colour matrix block: input FIFO, colour-correcting matrix with
 saturation, luma/chroma matrix, and an APB register slave.
 Assumes pixels and APB are synchronous to core_clk; gamma is applied
 ahead of the luma/chroma stage by a slot that is identity here.
*/
`timescale 1ns/1ps
`include "pcmt_regs.svh"

module pixel_fifo #(
	parameter int WIDTH = `PCMT_PIX_WIDTH,
	parameter int DEPTH = `PCMT_FIFO_DEPTH
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp, rp;
		logic [AW:0]                 count;
		logic                        rdy;
	} fifo_s;
	fifo_s st_r, st_nxt;
	logic  push, pop;

	// Ready is registered from the next count, so the writer sees an honest full.
	always_comb begin
		st_nxt = st_r;
		push   = inValid && st_r.rdy;
		pop    = outReady && (st_r.count != '0);
		if (push) begin
			st_nxt.mem[st_r.wp] = inData;
			st_nxt.wp           = st_r.wp + 1'b1;
		end
		if (pop) st_nxt.rp = st_r.rp + 1'b1;
		st_nxt.count = st_r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		st_nxt.rdy   = (st_nxt.count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r     <= '0;
			st_r.rdy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign inReady  = st_r.rdy;
	assign outValid = (st_r.count != '0);
	assign outData  = st_r.mem[st_r.rp];
	assign level    = st_r.count;
endmodule // pixel_fifo

module pixel_color_matrix_transform (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        inValid,
	output logic             inReady,
	input  wire logic [7:0]  inRed,
	input  wire logic [7:0]  inGreen,
	input  wire logic [7:0]  inBlue,
	output logic             outValid,
	input  wire logic        outReady,
	output logic [7:0]       outCh0,
	output logic [7:0]       outCh1,
	output logic [7:0]       outCh2,
	output logic [15:0]      whiteBalanceRedRatio,
	output logic [15:0]      whiteBalanceBlueRatio
);
	typedef struct packed {
		logic                 imagePipeOn, correctionMatrixOn;
		logic                 vividnessAdjustOn, lumaChromaFormat;
		pcmt_pkg::matrix_sel_e matrixInstanceSelect;
		logic [3:0]           coefficientIndexSelect;
		pcmt_pkg::illuminant_e illuminantPreset;
		logic [15:0]          wbRed, wbBlue, saturation;
		pcmt_pkg::coef_set_t  custom;
		logic [15:0]          pixCount;
		logic                 pready, pslverr;
		logic [31:0]          prdata;
		logic                 s1Valid;
		logic [7:0]           s1C0, s1C1, s1C2;
		logic                 oValid;
		logic [7:0]           o0, o1, o2;
	} state_s;

	state_s      st_r, st_nxt;
	logic        fifoValid, advance;
	logic [23:0] fifoData;
	logic [4:0]  fifoLevel;

	// Saturating conversion of a wide signed result to an 8-bit pixel.
	function automatic logic [7:0] clamp8(input logic signed [31:0] v);
		if (v < 0) return 8'h00;
		if (v > 32'sd255) return 8'hFF;
		return v[7:0];
	endfunction
	// One row of a matrix: gains on R, G, B, shifted back to pixel scale, plus offset.
	function automatic logic [7:0] applyRow(input logic [15:0] g0, input logic [15:0] g1,
			input logic [15:0] g2, input logic [15:0] off, input logic [7:0] r,
			input logic [7:0] g, input logic [7:0] b);
		logic signed [31:0] acc;
		acc = $signed({{16{g0[15]}}, g0}) * $signed({24'h000000, r})
			+ $signed({{16{g1[15]}}, g1}) * $signed({24'h000000, g})
			+ $signed({{16{g2[15]}}, g2}) * $signed({24'h000000, b});
		acc = (acc >>> `PCMT_FRAC_BITS) + $signed({{16{off[15]}}, off});
		return clamp8(acc);
	endfunction
	// Stored calibrated matrices: per-illuminant red and blue diagonal gains.
	function automatic logic [15:0] presetCoef(input pcmt_pkg::illuminant_e p,
			input logic [3:0] idx);
		logic [15:0] rg, bg;
		unique case (p)
			pcmt_pkg::ILLUM_TUNGSTEN: begin rg = 16'h00E6; bg = 16'h012C; end
			pcmt_pkg::ILLUM_WARM_FL:  begin rg = 16'h00EC; bg = 16'h0122; end
			pcmt_pkg::ILLUM_COOL_FL:  begin rg = 16'h00F6; bg = 16'h0114; end
			pcmt_pkg::ILLUM_CLOUDY:   begin rg = 16'h010E; bg = 16'h00F0; end
			pcmt_pkg::ILLUM_SHADE:    begin rg = 16'h011C; bg = 16'h00E6; end
			default:                  begin rg = `PCMT_COEF_ONE; bg = `PCMT_COEF_ONE; end
		endcase
		unique case (idx)
			4'h0:    return rg;
			4'h4:    return `PCMT_COEF_ONE;
			4'h8:    return bg;
			default: return 16'h0000;
		endcase
	endfunction
	// Fixed luma/chroma matrix in the same fixed-point scale, chroma offsets at mid-scale.
	localparam pcmt_pkg::coef_set_t LUMA_SET = {16'h0080, 16'h0080, 16'h0000, 16'hFFEB,
		16'hFF95, 16'h0080, 16'h0080, 16'hFFAB, 16'hFFD5, 16'h001D, 16'h0096, 16'h004D};
	function automatic logic [15:0] lumaCoef(input logic [3:0] idx);
		return (idx < `PCMT_NUM_COEFS) ? LUMA_SET[idx] : 16'h0000;
	endfunction
	// Coefficient in use for either matrix; indices above the offsets read as zero.
	function automatic logic [15:0] activeCoef(input state_s s, input pcmt_pkg::matrix_sel_e m,
			input logic [3:0] idx);
		if (idx >= `PCMT_NUM_COEFS) return 16'h0000;
		if (m == pcmt_pkg::MATRIX_LUMA_CHROMA) return lumaCoef(idx);
		if (s.illuminantPreset == pcmt_pkg::ILLUM_CUSTOM) return s.custom[idx];
		return presetCoef(s.illuminantPreset, idx);
	endfunction
	// Moves one channel away from grey by the saturation gain, clamped.
	function automatic logic [7:0] vivid(input logic [7:0] c, input logic [7:0] grey,
			input logic [15:0] sat);
		logic signed [31:0] d;
		d = $signed({24'h000000, c}) - $signed({24'h000000, grey});
		d = (d * $signed({16'h0000, sat})) >>> `PCMT_FRAC_BITS;
		return clamp8($signed({24'h000000, grey}) + d);
	endfunction

	pixel_fifo #(
		.WIDTH(`PCMT_PIX_WIDTH),
		.DEPTH(`PCMT_FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.nrst    (nrst),
		.inValid (inValid),
		.inReady (inReady),
		.inData  ({inRed, inGreen, inBlue}),
		.outValid(fifoValid),
		.outReady(advance),
		.outData (fifoData),
		.level   (fifoLevel)
	);

	// Register slave and both pipeline stages; the whole pipe stalls on output back-pressure.
	always_comb begin
		logic [7:0]  r, g, b;
		logic [7:0]  c0, c1, c2, grey;
		logic [9:0]  lsum;
		logic        gated, access, err;
		logic [31:0] rd;
		logic [15:0] k [12];
		st_nxt       = st_r;
		{r, g, b}    = fifoData;
		{c0, c1, c2} = {r, g, b};
		for (int i = 0; i < 12; i++) begin
			k[i] = activeCoef(st_r, pcmt_pkg::MATRIX_CORRECTION, 4'(i));
		end
		advance = !st_r.oValid || outReady;

		// Stage one: correcting matrix, then the vividness adjustment.
		if (st_r.imagePipeOn && st_r.correctionMatrixOn) begin
			c0 = applyRow(k[0], k[1], k[2], k[9], r, g, b);
			c1 = applyRow(k[3], k[4], k[5], k[10], r, g, b);
			c2 = applyRow(k[6], k[7], k[8], k[11], r, g, b);
		end
		lsum = {2'b00, c0} + {1'b0, c1, 1'b0} + {2'b00, c2};
		grey = lsum[9:2];
		if (st_r.imagePipeOn && st_r.vividnessAdjustOn) begin
			c0 = vivid(c0, grey, st_r.saturation);
			c1 = vivid(c1, grey, st_r.saturation);
			c2 = vivid(c2, grey, st_r.saturation);
		end
		if (advance) begin
			st_nxt.s1Valid = fifoValid;
			{st_nxt.s1C0, st_nxt.s1C1, st_nxt.s1C2} = {c0, c1, c2};
			// Stage two sits after the gamma slot, fed only from stage one.
			st_nxt.oValid = st_r.s1Valid;
			{st_nxt.o0, st_nxt.o1, st_nxt.o2} = {st_r.s1C0, st_r.s1C1, st_r.s1C2};
			if (st_r.imagePipeOn && st_r.lumaChromaFormat) begin
				st_nxt.o0 = applyRow(lumaCoef(4'h0), lumaCoef(4'h1), lumaCoef(4'h2),
					lumaCoef(4'h9), st_r.s1C0, st_r.s1C1, st_r.s1C2);
				st_nxt.o1 = applyRow(lumaCoef(4'h3), lumaCoef(4'h4), lumaCoef(4'h5),
					lumaCoef(4'hA), st_r.s1C0, st_r.s1C1, st_r.s1C2);
				st_nxt.o2 = applyRow(lumaCoef(4'h6), lumaCoef(4'h7), lumaCoef(4'h8),
					lumaCoef(4'hB), st_r.s1C0, st_r.s1C1, st_r.s1C2);
			end
		end
		if (st_r.oValid && outReady) st_nxt.pixCount = st_r.pixCount + 16'h0001;

		// Setup phase decodes and latches the answer, so the access phase needs no wait.
		gated  = !st_r.imagePipeOn && (paddr != `PCMT_REG_CTRL);
		access = psel && penable && st_r.pready;
		err    = gated;
		rd     = 32'h00000000;
		unique case (paddr)
			`PCMT_REG_CTRL: begin
				rd = {28'h0000000, st_r.lumaChromaFormat, st_r.vividnessAdjustOn,
					st_r.correctionMatrixOn, st_r.imagePipeOn};
			end
			`PCMT_REG_SELECT: begin
				rd = {24'h000000, st_r.coefficientIndexSelect, 3'b000, st_r.matrixInstanceSelect};
			end
			`PCMT_REG_COEF: begin
				rd = {16'h0000, activeCoef(st_r, st_r.matrixInstanceSelect,
					st_r.coefficientIndexSelect)};
				// Writes land only in the custom correcting set.
				if (pwrite && (st_r.matrixInstanceSelect != pcmt_pkg::MATRIX_CORRECTION
						|| st_r.illuminantPreset != pcmt_pkg::ILLUM_CUSTOM
						|| st_r.coefficientIndexSelect >= `PCMT_NUM_COEFS)) begin
					err = 1'b1;
				end
			end
			`PCMT_REG_PRESET:  rd = {29'h00000000, st_r.illuminantPreset};
			`PCMT_REG_WB_RED:  rd = {16'h0000, st_r.wbRed};
			`PCMT_REG_WB_BLUE: rd = {16'h0000, st_r.wbBlue};
			`PCMT_REG_SAT:     rd = {16'h0000, st_r.saturation};
			`PCMT_REG_STATUS:  rd = {11'h000, fifoLevel, st_r.pixCount};
			default:           err = 1'b1;
		endcase
		if (psel && !penable) begin
			st_nxt.prdata  = (err || pwrite) ? 32'h00000000 : rd;
			st_nxt.pslverr = err;
		end

		// Writes take effect at the access edge; an erroring write changes nothing.
		if (access && pwrite && !st_r.pslverr) begin
			unique case (paddr)
				`PCMT_REG_CTRL: begin
					st_nxt.imagePipeOn        = pwdata[`PCMT_CTRL_PIPE_BIT];
					st_nxt.correctionMatrixOn = pwdata[`PCMT_CTRL_CCM_BIT];
					st_nxt.vividnessAdjustOn  = pwdata[`PCMT_CTRL_SAT_BIT];
					st_nxt.lumaChromaFormat   = pwdata[`PCMT_CTRL_YUV_BIT];
				end
				`PCMT_REG_SELECT: begin
					st_nxt.matrixInstanceSelect =
						pcmt_pkg::matrix_sel_e'(pwdata[`PCMT_SEL_MAT_BIT]);
					st_nxt.coefficientIndexSelect =
						pwdata[`PCMT_SEL_IDX_MSB:`PCMT_SEL_IDX_LSB];
				end
				`PCMT_REG_COEF: begin
					st_nxt.custom[st_r.coefficientIndexSelect] = pwdata[15:0];
				end
				`PCMT_REG_PRESET: begin
					st_nxt.illuminantPreset = pcmt_pkg::illuminant_e'(pwdata[2:0]);
					if (st_nxt.illuminantPreset != pcmt_pkg::ILLUM_CUSTOM) begin
						st_nxt.wbRed  = presetCoef(st_nxt.illuminantPreset, 4'h0);
						st_nxt.wbBlue = presetCoef(st_nxt.illuminantPreset, 4'h8);
					end
				end
				`PCMT_REG_WB_RED:  st_nxt.wbRed = pwdata[15:0];
				`PCMT_REG_WB_BLUE: st_nxt.wbBlue = pwdata[15:0];
				`PCMT_REG_SAT:     st_nxt.saturation = pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Custom set starts as identity so switching to it passes pixels unchanged.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r            <= '0;
			st_r.pready     <= 1'b1;
			st_r.wbRed      <= `PCMT_WB_RESET;
			st_r.wbBlue     <= `PCMT_WB_RESET;
			st_r.saturation <= `PCMT_SAT_RESET;
			st_r.custom[0]  <= `PCMT_COEF_ONE;
			st_r.custom[4]  <= `PCMT_COEF_ONE;
			st_r.custom[8]  <= `PCMT_COEF_ONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata                = st_r.prdata;
	assign pready                = st_r.pready;
	assign pslverr               = st_r.pslverr;
	assign outValid              = st_r.oValid;
	assign outCh0                = st_r.o0;
	assign outCh1                = st_r.o1;
	assign outCh2                = st_r.o2;
	assign whiteBalanceRedRatio  = st_r.wbRed;
	assign whiteBalanceBlueRatio = st_r.wbBlue;
endmodule // pixel_color_matrix_transform

// File: test/pcmt_assertions.sv
/*
 Port checker of the colour matrix block.
 Assumes a bind to the top module; it sees only that module's ports.
*/
`timescale 1ns/1ps
`include "pcmt_regs.svh"
module pcmt_checker (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        inValid,
	input wire logic        inReady,
	input wire logic        outValid,
	input wire logic        outReady,
	input wire logic [7:0]  outCh0,
	input wire logic [7:0]  outCh1,
	input wire logic [7:0]  outCh2,
	input wire logic [15:0] whiteBalanceRedRatio,
	input wire logic [15:0] whiteBalanceBlueRatio
);
	logic [7:0] inFlight_r;
	logic       pipeOn_r;

	// Pixels held inside the block, and the pipe enable as software last wrote it.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			inFlight_r <= 8'h00;
			pipeOn_r   <= 1'b0;
		end else begin
			inFlight_r <= inFlight_r + 8'(inValid && inReady) - 8'(outValid && outReady);
			if (psel && penable && pwrite && paddr == `PCMT_REG_CTRL)
				pipeOn_r <= pwdata[`PCMT_CTRL_PIPE_BIT];
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// The first edge after release only sees reset in the past, so it stays vacuous.
	a_ready_high: assert property ($past(nrst) |-> pready)
		else $error("pready low after reset");
	a_out_hold: assert property (outValid && !outReady |=>
		outValid && $stable({outCh0, outCh1, outCh2})) else $error("output lost in stall");
	a_out_pending: assert property (outValid |-> inFlight_r != 8'h00)
		else $error("output without input");
	a_bad_addr: assert property (psel && !penable && paddr > `PCMT_REG_STATUS |=> pslverr)
		else $error("unmapped address accepted");
	a_ctrl_open: assert property (psel && !penable && paddr == `PCMT_REG_CTRL |=> !pslverr)
		else $error("control refused");
	a_gate_off: assert property (psel && !penable && paddr != `PCMT_REG_CTRL && !pipeOn_r
		|=> pslverr && prdata == 32'h0) else $error("register open with pipe off");
	a_upper_zero: assert property (psel && !penable && !pwrite && paddr == `PCMT_REG_COEF
		|=> prdata[31:16] == 16'h0) else $error("coefficient upper bits set");
	a_wb_write: assert property ($changed({whiteBalanceRedRatio, whiteBalanceBlueRatio})
		|-> $past(psel && penable && pwrite)) else $error("ratio changed without write");

	c_stall: cover property (outValid && !outReady);
	c_out: cover property (outValid && outReady);
	c_err: cover property (psel && penable && pslverr);
	c_full: cover property (!inReady);
endmodule // pcmt_checker

// File: test/pix_sink.sv
/*
 Downstream stage model: takes output pixels with random back-pressure.
 Assumes hold comes from the bench and forces a full stall.
*/
`timescale 1ns/1ps
module pix_sink (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic hold,
	output logic      outReady
);
	// A busy stage refuses about one cycle in four, so stalls hit at random places.
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			outReady <= 1'b0;
		end else begin
			outReady <= !hold && ($urandom_range(3) != 0);
		end
	end
endmodule // pix_sink

// File: test/tb.sv
/*
 Self-checking bench of the colour matrix block: APB register checks and
 random pixel streams against a reference model. Assumes the design files.
*/
`timescale 1ns/1ps
`include "pcmt_regs.svh"
module tb;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, inReady, outValid, outReady, hold = 1'b0;
	logic        inValid = 1'b0;
	logic [7:0]  inRed = 8'h00, inGreen = 8'h00, inBlue = 8'h00;
	logic [7:0]  outCh0, outCh1, outCh2;
	logic [15:0] whiteBalanceRedRatio, whiteBalanceBlueRatio;
	int          cm[12];
	int          lm[12] = '{77, 150, 29, -43, -85, 128, 128, -107, -21, 0, 128, 128};
	int          pR[7] = '{16'h100, 16'hE6, 16'hEC, 16'hF6, 16'h100, 16'h10E, 16'h11C};
	int          pB[7] = '{16'h100, 16'h12C, 16'h122, 16'h114, 16'h100, 16'hF0, 16'hE6};
	logic [3:0]  cfg[5] = '{4'h1, 4'h3, 4'h7, 4'hB, 4'hF};
	bit          ccmOn, satOn, yuvOn;
	int          sat, nOut, error_cnt, n_tests;
	logic [23:0] q[$];

	always #50 core_clk = ~core_clk;

	pixel_color_matrix_transform uut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .inValid, .inReady, .inRed, .inGreen, .inBlue,
		.outValid, .outReady, .outCh0, .outCh1, .outCh2, .whiteBalanceRedRatio,
		.whiteBalanceBlueRatio);
	pix_sink sink (.core_clk, .nrst, .hold, .outReady);

	function automatic int cl(int v);
		return (v < 0) ? 0 : ((v > 255) ? 255 : v);
	endfunction
	function automatic int dot(int m[12], int i, int a, int b, int c);
		return cl(((m[3*i] * a + m[3*i+1] * b + m[3*i+2] * c) >>> 8) + m[9+i]);
	endfunction
	// Reference pixel path: correction, then vividness, then luma/chroma last.
	function automatic logic [23:0] model(int r, int g, int b);
		int c[3];
		int t[3];
		int gy;
		c = '{r, g, b};
		if (ccmOn) c = '{dot(cm, 0, r, g, b), dot(cm, 1, r, g, b), dot(cm, 2, r, g, b)};
		gy = (c[0] + 2 * c[1] + c[2]) >> 2;
		if (satOn) foreach (c[i]) c[i] = cl(gy + (((c[i] - gy) * sat) >>> 8));
		t = c;
		if (yuvOn) foreach (c[i]) c[i] = dot(lm, i, t[0], t[1], t[2]);
		return {8'(c[0]), 8'(c[1]), 8'(c[2])};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		check(32'(e), 32'(ee));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, x);
		check(32'(e), 32'(ee));
	endtask

	// Pixels go in one at a time; the first two are full scale and black.
	task automatic send(input int n, output int k);
		k = 0;
		inValid <= 1'b1;
		{inRed, inGreen, inBlue} <= 24'hFFFFFF;
		for (int t = 0; t < 20 * n + 50 && k < n; t++) begin
			@(posedge core_clk);
			if (inReady) begin
				k++;
				{inRed, inGreen, inBlue} <= (k == 1) ? 24'h0 : 24'($urandom);
			end
		end
		inValid <= 1'b0;
	endtask
	task automatic drain();
		for (int t = 0; t < 2000 && q.size() != 0; t++) @(posedge core_clk);
		check(32'(q.size()), 32'h0);
	endtask

	// Expected pixels are queued on acceptance and compared in order on delivery.
	always @(posedge core_clk) begin
		if (inValid && inReady) q.push_back(model(inRed, inGreen, inBlue));
		if (outValid && outReady) begin
			nOut++;
			check(32'({outCh0, outCh1, outCh2}), 32'(q.pop_front()));
		end
	end

	initial begin
		#(100 * 30000);
		error_cnt++;
		test_done();
	end

	initial begin
		int k;
		void'($urandom(32'h6D633133));
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		check(32'(whiteBalanceRedRatio), 32'h100);
		rd(`PCMT_REG_CTRL, 32'h0, 1'b0);
		rd(`PCMT_REG_SAT, 32'h0, 1'b1);
		wr(`PCMT_REG_CTRL, 32'h1, 1'b0);
		rd(`PCMT_REG_SAT, 32'h100, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		for (int i = 0; i < 13; i++) begin
			wr(`PCMT_REG_SELECT, 32'(i) << 4, 1'b0);
			rd(`PCMT_REG_COEF, (i < 9 && i % 4 == 0) ? 32'h100 : 32'h0, 1'b0);
			wr(`PCMT_REG_SELECT, (32'(i) << 4) | 32'h1, 1'b0);
			rd(`PCMT_REG_COEF, (i < 12) ? 32'(lm[i]) & 32'hFFFF : 32'h0, 1'b0);
		end
		wr(`PCMT_REG_COEF, 32'h0, 1'b1);
		for (int p = 0; p < 7; p++) begin
			wr(`PCMT_REG_PRESET, 32'(p), 1'b0);
			check(32'(whiteBalanceRedRatio), 32'(pR[p]));
			check(32'(whiteBalanceBlueRatio), 32'(pB[p]));
			wr(`PCMT_REG_SELECT, 32'h0, 1'b0);
			rd(`PCMT_REG_COEF, 32'(pR[p]), 1'b0);
			wr(`PCMT_REG_SELECT, 32'h80, 1'b0);
			rd(`PCMT_REG_COEF, 32'(pB[p]), 1'b0);
		end
		wr(`PCMT_REG_COEF, 32'h0, 1'b1);
		wr(`PCMT_REG_WB_RED, 32'h155, 1'b0);
		wr(`PCMT_REG_PRESET, 32'h7, 1'b0);
		check(32'(whiteBalanceRedRatio), 32'h155);
		for (int i = 0; i < 12; i++) begin
			cm[i] = (i < 9) ? int'($urandom_range(400)) - 100 : int'($urandom_range(80)) - 40;
			wr(`PCMT_REG_SELECT, 32'(i) << 4, 1'b0);
			wr(`PCMT_REG_COEF, 32'(cm[i]) & 32'hFFFF, 1'b0);
			rd(`PCMT_REG_COEF, 32'(cm[i]) & 32'hFFFF, 1'b0);
		end
		// Each setting streams pixels: bypass, correction, correction with vividness, correction with luma/chroma, then all three.
		foreach (cfg[m]) begin
			{yuvOn, satOn, ccmOn} = cfg[m][3:1];
			sat = $urandom_range(512);
			wr(`PCMT_REG_SAT, 32'(sat), 1'b0);
			wr(`PCMT_REG_CTRL, 32'(cfg[m]), 1'b0);
			send(24, k);
			check(32'(k), 32'h18);
			drain();
		end
		hold <= 1'b1;
		send(40, k);
		check(32'(k >= 16 && k <= 19), 32'h1);
		check(32'(inReady), 32'h0);
		hold <= 1'b0;
		drain();
		rd(`PCMT_REG_STATUS, 32'(nOut & 16'hFFFF), 1'b0);
		wr(`PCMT_REG_CTRL, 32'h0, 1'b0);
		rd(`PCMT_REG_COEF, 32'h0, 1'b1);
		test_done();
	end
endmodule // tb

bind pixel_color_matrix_transform pcmt_checker chk (.core_clk, .nrst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .inValid, .inReady, .outValid,
	.outReady, .outCh0, .outCh1, .outCh2, .whiteBalanceRedRatio, .whiteBalanceBlueRatio);
